/* File: fp_cmp_pkg.sv */
//
// Functional notes
// - Write all-ones mask if predicate holds, else zeros.
// - Single format mask fills destination bits 0..31.
// - Format 10100 is single, 10101 is double.
// - Other format codes raise reserved instruction.
// - Bits 2,1 relation; bit0 NaN; bit3 signalling; bit4 negate.
// - Unassigned predicate codes raise reserved instruction.
// - Signalling NaN or signalling quiet-NaN sets invalid flag.
// - Invalid enable set: suppress write, take exception.
// - Any NaN operand makes unordered true.
// - Positive and negative zero compare equal.
// - Exact compare, no overflow or underflow.
// - One of greater, less, equal, unordered holds.
// - Negated symmetric predicates are implemented directly.
// - Codes 0..7: false,un,eq,ueq,lt,ult,le,ule.
package fp_cmp_pkg;

  localparam logic [4:0] FMT_SINGLE = 5'h14;
  localparam logic [4:0] FMT_DOUBLE = 5'h15;

  localparam int unsigned COND_UN_BIT = 0;
  localparam int unsigned COND_EQ_BIT = 1;
  localparam int unsigned COND_LT_BIT = 2;
  localparam int unsigned COND_SIG_BIT = 3;
  localparam int unsigned COND_NEG_BIT = 4;

  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_MASK = 4'h8;
  localparam logic [3:0] REG_LAST = 4'hc;

  localparam int unsigned CTRL_INV_EN_BIT = 0;
  localparam int unsigned CTRL_INV_FLAG_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_INVALID_BIT = 1;
  localparam int unsigned IRQ_RESERVED_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  localparam int unsigned LAST_REL_LSB = 0;
  localparam int unsigned LAST_MASK_BIT = 4;
  localparam int unsigned LAST_COUNT_LSB = 16;
  localparam int unsigned COUNT_W = 16;

  typedef struct packed {
    logic [4:0] fmt;
    logic [4:0] condn;
    logic [4:0] destination_operand;
    logic [63:0] first_source_operand;
    logic [63:0] second_source_operand;
  } cmp_req_t;

  typedef struct packed {
    logic wr_en;
    logic [4:0] index;
    logic [63:0] data;
  } cmp_resp_t;

  typedef struct packed {
    logic nan;
    logic snan;
    logic qnan;
    logic zero;
    logic sign;
    logic [62:0] mag;
  } fp_class_t;

  typedef struct packed {
    logic gt;
    logic lt;
    logic eq;
    logic un;
  } relation_t;

endpackage : fp_cmp_pkg

/* File: fp_operand_classify.sv */
`timescale 1ns/1ps
`default_nettype none
module fp_operand_classify
(
  // Operand.
  input wire logic is_single,
  input wire logic [63:0] value,
  // Classification.
  output fp_cmp_pkg::fp_class_t cls
);
  import fp_cmp_pkg::*;

  wire exp_ones_s = (value[30:23] == 8'hff);
  wire exp_ones_d = (value[62:52] == 11'h7ff);
  wire frac_nz_s = |value[22:0];
  wire frac_nz_d = |value[51:0];
  wire nan_s = exp_ones_s && frac_nz_s;
  wire nan_d = exp_ones_d && frac_nz_d;
  wire quiet_s = value[22];
  wire quiet_d = value[51];
  wire nan_w = is_single ? nan_s : nan_d;
  wire quiet_w = is_single ? quiet_s : quiet_d;
  // Singles are left-aligned so one magnitude compare serves both formats.
  wire [62:0] mag_w = is_single ? {value[30:0], 32'h0} : value[62:0];

  assign cls.nan = nan_w;
  assign cls.snan = nan_w && !quiet_w;
  assign cls.qnan = nan_w && quiet_w;
  assign cls.zero = (mag_w == 63'h0);
  assign cls.sign = is_single ? value[31] : value[63];
  assign cls.mag = mag_w;

endmodule : fp_operand_classify
`default_nettype wire

/* File: fp_relation_compare.sv */
`timescale 1ns/1ps
`default_nettype none
module fp_relation_compare
(
  // Classified operands.
  input wire fp_cmp_pkg::fp_class_t a,
  input wire fp_cmp_pkg::fp_class_t b,
  // Exactly one relation is set.
  output fp_cmp_pkg::relation_t rel
);
  import fp_cmp_pkg::*;

  // Pure magnitude and sign comparison: exact, no rounding, no range flags.
  wire un_w = a.nan || b.nan;
  wire both_zero = a.zero && b.zero;
  wire same_bits = (a.sign == b.sign) && (a.mag == b.mag);
  wire eq_w = !un_w && (both_zero || same_bits);
  wire mag_lt = a.mag < b.mag;
  wire mag_gt = a.mag > b.mag;
  wire raw_lt = (a.sign != b.sign) ? a.sign : (a.sign ? mag_gt : mag_lt);
  wire lt_w = !un_w && !eq_w && raw_lt;

  assign rel.un = un_w;
  assign rel.eq = eq_w;
  assign rel.lt = lt_w;
  assign rel.gt = !un_w && !eq_w && !raw_lt;

endmodule : fp_relation_compare
`default_nettype wire

/* File: fp_compare_to_mask.sv */
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fp_compare_to_mask
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [fp_cmp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Issue from the pipeline.
  input wire logic req_valid,
  input wire fp_cmp_pkg::cmp_req_t req,
  // Writeback to the fp_register file.
  output logic resp_valid,
  output fp_cmp_pkg::cmp_resp_t resp,
  // Exceptions.
  output logic exc_reserved,
  output logic exc_invalid,
  // Interrupt.
  output logic irq
);
  import fp_cmp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Format and predicate decode.

  wire fmt_is_single = (req.fmt == FMT_SINGLE);
  wire fmt_is_double = (req.fmt == FMT_DOUBLE);
  wire fmt_ok = fmt_is_single || fmt_is_double;

  wire cond_neg = req.condn[COND_NEG_BIT];
  wire cond_sig = req.condn[COND_SIG_BIT];
  wire cond_un = req.condn[COND_UN_BIT];
  wire cond_eq = req.condn[COND_EQ_BIT];
  wire cond_lt = req.condn[COND_LT_BIT];

  // Negated forms exist only for the symmetric predicates or, une and ne.
  wire neg_ok = !cond_lt && (cond_eq || cond_un);
  wire cond_ok = !cond_neg || neg_ok;

  wire reserved_w = !fmt_ok || !cond_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Operand classification and ordering relation.

  fp_class_t cls_first;
  fp_class_t cls_second;
  relation_t rel;

  fp_operand_classify u_class_first
  (
    .is_single(fmt_is_single),
    .value(req.first_source_operand),
    .cls(cls_first)
  );

  fp_operand_classify u_class_second
  (
    .is_single(fmt_is_single),
    .value(req.second_source_operand),
    .cls(cls_second)
  );

  fp_relation_compare u_relation
  (
    .a(cls_first),
    .b(cls_second),
    .rel(rel)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Predicate evaluation.

  // Low three code bits pick unordered, equal and less terms.
  wire term_un = cond_un && rel.un;
  wire term_eq = cond_eq && rel.eq;
  wire term_lt = cond_lt && rel.lt;
  wire base_pred = term_un || term_eq || term_lt;
  wire pred_true = cond_neg ? !base_pred : base_pred;

  wire [63:0] mask_dbl = {64{pred_true}};
  wire [63:0] mask_sgl = {32'h0, {32{pred_true}}};
  wire [63:0] mask_w = fmt_is_single ? mask_sgl : mask_dbl;

  //////////////////////////////////////////////////////////////////////////////
  // Invalid-operation detection.

  wire any_snan = cls_first.snan || cls_second.snan;
  wire any_qnan = cls_first.qnan || cls_second.qnan;
  // Quiet predicates let quiet NaNs through without raising anything.
  wire invalid_w = any_snan || (cond_sig && any_qnan);

  wire exec = req_valid && !reserved_w;
  wire exec_invalid = exec && invalid_w;
  wire exec_reserved = req_valid && reserved_w;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic inv_en_q;
  logic inv_flag_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  relation_t last_rel_q;
  logic last_mask_q;
  logic [COUNT_W-1:0] count_q;

  wire sel_ctrl = (reg_addr == REG_CTRL);
  wire sel_status = (reg_addr == REG_IRQ_STATUS);
  wire sel_mask = (reg_addr == REG_IRQ_MASK);
  wire sel_last = (reg_addr == REG_LAST);

  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_status = reg_wr && sel_status;
  wire wr_mask = reg_wr && sel_mask;

  wire inv_take = exec_invalid && inv_en_q;
  wire write_ok = exec && !inv_take;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state values.

  // Sticky invalid flag; a new event wins over a software clear.
  wire inv_flag_d = exec_invalid
    ? 1'b1
    : (wr_ctrl ? reg_wdata[CTRL_INV_FLAG_BIT] : inv_flag_q);
  wire inv_en_d = wr_ctrl ? reg_wdata[CTRL_INV_EN_BIT] : inv_en_q;

  wire [IRQ_W-1:0] irq_event;
  assign irq_event[IRQ_DONE_BIT] = write_ok;
  assign irq_event[IRQ_INVALID_BIT] = exec_invalid;
  assign irq_event[IRQ_RESERVED_BIT] = exec_reserved;

  wire [IRQ_W-1:0] irq_clear = wr_status ? reg_wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_status_d = (irq_status_q & ~irq_clear) | irq_event;
  wire [IRQ_W-1:0] irq_mask_d = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_q;
  wire irq_d = |(irq_status_d & irq_mask_d);

  wire [COUNT_W-1:0] count_d = write_ok ? count_q + 1'b1 : count_q;

  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] mask_word;
  logic [31:0] last_word;

  always_comb
  begin
    ctrl_word = 32'h0;
    ctrl_word[CTRL_INV_EN_BIT] = inv_en_q;
    ctrl_word[CTRL_INV_FLAG_BIT] = inv_flag_q;
    status_word = 32'h0;
    status_word[IRQ_W-1:0] = irq_status_q;
    mask_word = 32'h0;
    mask_word[IRQ_W-1:0] = irq_mask_q;
    last_word = 32'h0;
    last_word[LAST_REL_LSB +: 4] = last_rel_q;
    last_word[LAST_MASK_BIT] = last_mask_q;
    last_word[LAST_COUNT_LSB +: COUNT_W] = count_q;
  end

  wire [31:0] rdata_sel =
    sel_ctrl ? ctrl_word :
    sel_status ? status_word :
    sel_mask ? mask_word :
    sel_last ? last_word : 32'h0;
  wire [31:0] rdata_d = reg_rd ? rdata_sel : 32'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Control and status registers.

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      inv_en_q <= CTRL_RESET[CTRL_INV_EN_BIT];
      inv_flag_q <= CTRL_RESET[CTRL_INV_FLAG_BIT];
      irq_status_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
      irq <= 1'b0;
      reg_rdata <= 32'h0;
    end
    else
    begin
      inv_en_q <= inv_en_d;
      inv_flag_q <= inv_flag_d;
      irq_status_q <= irq_status_d;
      irq_mask_q <= irq_mask_d;
      irq <= irq_d;
      reg_rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Last compare record.

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      last_rel_q <= '0;
      last_mask_q <= 1'b0;
      count_q <= '0;
    end
    else
    begin
      if (exec)
      begin
        last_rel_q <= rel;
        last_mask_q <= pred_true;
      end
      count_q <= count_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writeback and exceptions, one cycle after issue.

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp <= '0;
      exc_reserved <= 1'b0;
      exc_invalid <= 1'b0;
    end
    else
    begin
      resp_valid <= req_valid;
      resp.wr_en <= write_ok;
      resp.index <= req.destination_operand;
      resp.data <= write_ok ? mask_w : 64'h0;
      exc_reserved <= exec_reserved;
      exc_invalid <= inv_take;
    end
  end

endmodule : fp_compare_to_mask
`default_nettype wire

/* File: fp_cmp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fp_cmp_chk
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [fp_cmp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Compare path.
  input wire logic req_valid,
  input wire fp_cmp_pkg::cmp_req_t req,
  input wire logic resp_valid,
  input wire fp_cmp_pkg::cmp_resp_t resp,
  input wire logic exc_reserved,
  input wire logic exc_invalid,
  input wire logic irq
);
  import fp_cmp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire fmt_ok = req.fmt == FMT_SINGLE || req.fmt == FMT_DOUBLE;
  wire cond_ok = !req.condn[4] || req.condn inside {5'h11, 5'h12, 5'h13, 5'h19, 5'h1a, 5'h1b};
  property p_pulse; resp_valid == $past(req_valid); endproperty
  a_pulse: assert property (p_pulse) else $error("answer pulse misplaced");
  property p_fmt; req_valid && !fmt_ok |=> exc_reserved && !resp.wr_en; endproperty
  a_fmt: assert property (p_fmt) else $error("bad format not trapped");
  property p_cond; req_valid && fmt_ok && !cond_ok |=> exc_reserved && !resp.wr_en; endproperty
  a_cond: assert property (p_cond) else $error("bad predicate not trapped");
  property p_single; req_valid && req.fmt == FMT_SINGLE |=> resp.data[63:32] == 32'h0; endproperty
  a_single: assert property (p_single) else $error("single mask upper half set");
  property p_false; req_valid && fmt_ok && req.condn == 5'h0 |=> resp.data == 64'h0; endproperty
  a_false: assert property (p_false) else $error("always-false gave ones");
  property p_mask; req_valid && req.fmt == FMT_DOUBLE |=> !resp.wr_en || &resp.data || ~|resp.data;
  endproperty
  a_mask: assert property (p_mask) else $error("mask not uniform");
  property p_trap; exc_invalid |-> resp_valid && !resp.wr_en && !exc_reserved; endproperty
  a_trap: assert property (p_trap) else $error("trapped compare wrote");
  property p_index; req_valid |=> !resp.wr_en || resp.index == $past(req.destination_operand);
  endproperty
  a_index: assert property (p_index) else $error("wrong destination");
endmodule : fp_cmp_chk
`default_nettype wire

/* File: pipe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pipe_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Command from the bench.
  input wire logic issue,
  input wire logic swap,
  input wire fp_cmp_pkg::cmp_req_t cmd,
  // Issue toward the unit.
  output logic req_valid,
  output fp_cmp_pkg::cmp_req_t req
);
  import fp_cmp_pkg::*;
  cmp_req_t cmd_x;
  always_comb
  begin
    cmd_x = cmd;
    if (swap)
    begin
      cmd_x.first_source_operand = cmd.second_source_operand;
      cmd_x.second_source_operand = cmd.first_source_operand;
    end
  end
  // Fields are scrambled between issues so nothing can lean on stale values.
  always_ff @(posedge clk)
  begin
    req_valid <= rst_n && issue;
    req <= !rst_n ? '0 : issue ? cmd_x : ~req;
  end
endmodule : pipe_model
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fp_cmp_pkg::*;
  localparam logic [63:0] ONE = 64'h3ff0000000000000;
  localparam logic [63:0] TWO = 64'h4000000000000000;
  localparam logic [63:0] QN = 64'h7ff8000000000000;
  localparam logic [63:0] SN = 64'h7ff0000000000001;
  logic clk, rst_n, reg_wr, reg_rd, issue, swap, req_valid, resp_valid;
  logic exc_reserved, exc_invalid, irq;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  cmp_req_t cmd, req;
  cmp_resp_t resp;
  int error_cnt, total_checks;
  pipe_model pm_u (.clk, .rst_n, .issue, .swap, .cmd, .req_valid, .req);
  fp_compare_to_mask dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_valid, .req, .resp_valid, .resp, .exc_reserved, .exc_invalid, .irq);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [69:0] seen, input logic [69:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic run(input logic [4:0] f, input logic [4:0] c, input logic [63:0] a,
    input logic [63:0] b);
    @(posedge clk);
    cmd <= '{f, c, 5'h3, a, b};
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
    #1 chk(resp_valid, 1'b1);
  endtask : run
  // Relation vector is {gt, lt, eq, un}.
  function automatic logic pred(input logic [4:0] c, input logic [3:0] r);
    return ((c[0] & r[0]) | (c[1] & r[1]) | (c[2] & r[2])) ^ c[4];
  endfunction : pred
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_codes;
    logic [63:0] ops [8] = '{ONE, TWO, TWO, ONE, 64'h0, 64'h8000000000000000, QN, QN};
    logic [3:0] rels [4] = '{4'h4, 4'h8, 4'h2, 4'h1};
    logic r;
    logic [63:0] m;
    for (int c = 0; c < 32; c++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        r = c[4] && !(c inside {17, 18, 19, 25, 26, 27});
        m = {64{pred(c[4:0], rels[k])}};
        run(FMT_DOUBLE, c[4:0], ops[2*k], ops[2*k+1]);
        chk({exc_reserved, resp.wr_en}, {r, !r});
        chk(resp.data, r ? 64'h0 : m);
      end
    end
  endtask : s_codes
  task automatic s_formats;
    for (int f = 0; f < 32; f++)
    begin
      run(f[4:0], 5'h2, ONE, ONE);
      chk(exc_reserved, !(f == 20 || f == 21));
    end
    run(FMT_SINGLE, 5'h4, 64'h3f800000, 64'h40000000);
    chk(resp, {1'b1, 5'h3, 32'h0, 32'hffffffff});
    swap <= 1'b1;
    run(FMT_DOUBLE, 5'h4, ONE, TWO);
    chk(resp.data, 64'h0);
    swap <= 1'b0;
  endtask : s_formats
  task automatic s_invalid;
    wr(REG_CTRL, 32'h0);
    run(FMT_DOUBLE, 5'h1, QN, ONE);
    rd(REG_CTRL, 32'h0);
    run(FMT_DOUBLE, 5'h2, SN, ONE);
    chk({resp.wr_en, resp.data}, {1'b1, 64'h0});
    rd(REG_CTRL, 32'h2);
    wr(REG_CTRL, 32'h1);
    run(FMT_DOUBLE, 5'h9, QN, ONE);
    chk({exc_invalid, resp.wr_en}, 2'b10);
    rd(REG_CTRL, 32'h3);
    wr(REG_CTRL, 32'h0);
  endtask : s_invalid
  task automatic s_irq;
    rd(4'h1, 32'h0);
    wr(REG_IRQ_STATUS, 32'h7);
    wr(REG_IRQ_MASK, 32'h1);
    run(FMT_DOUBLE, 5'h2, ONE, ONE);
    @(posedge clk);
    #1 chk(irq, 1'b1);
    wr(REG_IRQ_MASK, 32'h0);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h1);
    rd(REG_IRQ_STATUS, 32'h1);
    wr(REG_IRQ_STATUS, 32'h1);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    // The last record is read only: 95 written compares, last one equal and true.
    wr(REG_LAST, 32'hffffffff);
    rd(REG_LAST, 32'h005f0012);
  endtask : s_irq
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, issue, swap, reg_addr, reg_wdata} = '0;
    cmd = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, 32'h0);
    rd(REG_IRQ_STATUS, 32'h0);
    rd(REG_IRQ_MASK, 32'h0);
    s_codes();
    s_formats();
    s_invalid();
    s_irq();
    close_out();
  end
endmodule : tb_top
bind fp_compare_to_mask fp_cmp_chk chk_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .req_valid, .req, .resp_valid, .resp, .exc_reserved, .exc_invalid, .irq);
`default_nettype wire
